// File: rtl/pis_pkg.sv
// constants for the interrupt and power sequence register slice
package pis_pkg;
    localparam logic [7:0] OFS_IRQ_ALLOW_TWO = 8'h06;
    localparam logic [7:0] OFS_STATUS_ONE    = 8'h07;
    localparam logic [7:0] OFS_STATUS_TWO    = 8'h08;
    localparam logic [7:0] OFS_SLOT_ORDER    = 8'h09;
    // enable and flag positions in the second pair of registers
    localparam int BIT_BOOST     = 7;
    localparam int BIT_GATE_HIGH = 6;
    localparam int BIT_INVERTER  = 5;
    localparam int BIT_SRC_POS   = 4;
    localparam int BIT_GATE_LOW  = 3;
    localparam int BIT_UNUSED    = 2;
    localparam int BIT_SRC_NEG   = 1;
    localparam int BIT_CONV_DONE = 0;
    localparam logic [7:0] ALLOW_TWO_MASK  = 8'hfb;
    localparam logic [7:0] ALLOW_TWO_RESET = 8'hfb;
    localparam logic [7:0] STATUS_ONE_MASK = 8'h7c;
    localparam int         STATUS_ONE_LSB  = 2;
    // slot fields: gate high 7:6, source pos 5:4, gate low 3:2, source neg 1:0
    localparam logic [7:0] SLOT_ORDER_RESET = 8'he4;
    // timing
    localparam int CLK_HZ      = 50_000_000;
    localparam int MS_CYCLES   = CLK_HZ / 1000;
    localparam int UV_SHORT_MS = 5;
    localparam int UV_LONG_MS  = 10;
    localparam int UV_CNT_W    = 20;
    typedef enum logic [1:0] {PIS_OFF, PIS_UP, PIS_ON, PIS_DOWN} pis_seq_t;
endpackage

// File: rtl/pis_regs.sv
// interrupt enable, fault status and rail slot order registers with sequencer
//
// Overview of operation
// - enables: boost 7, gate high 6, inverter 5, src pos 4, gate low 3, src neg 1, done 0
// - enable bit 1 permits, 0 suppresses; used enables reset to 1
// - enable bit 2 is read-only zero and ignores writes
// - status one read-only: bits 6..2 thermal/thermistor/input flags, others zero
// - status two read-only, flags at enable positions, bit 2 zero
// - undervolt flag when rail misses regulation 5 ms after enable, converters 10 ms
// - slot field 00..11 picks strobe one to four for that rail
// - slot order fields 7:6, 5:4, 3:2, 1:0, reset 11, 10, 01, 00
// - power-down runs strobes in reverse order, fourth slot first
// - first strobe follows wake-up rise by programmed delay code in ms
module pis_regs #(
    parameter int MS_CYC        = pis_pkg::MS_CYCLES,
    parameter int UV_SHORT_CYC  = pis_pkg::UV_SHORT_MS * pis_pkg::MS_CYCLES,
    parameter int UV_LONG_CYC   = pis_pkg::UV_LONG_MS * pis_pkg::MS_CYCLES
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic       i_power_up_request_pin,
    input  wire logic [4:0] i_status_one_raw,
    input  wire logic [7:0] i_status_one_allow,
    input  wire logic [7:0] i_rail_good,
    input  wire logic       i_conv_done,
    input  wire logic [3:0] i_first_slot_delay,
    input  wire logic [3:0] i_slot_delay_two,
    input  wire logic [3:0] i_slot_delay_three,
    input  wire logic [3:0] i_slot_delay_four,
    output logic      [7:0] o_rail_on,
    output logic            o_slot_strobe,
    output logic      [1:0] o_slot_index,
    output logic            o_irq
);
    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [13:0] sync1_q;
    logic [13:0] sync2_q;
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            sync1_q <= 14'h0000;
            sync2_q <= 14'h0000;
        end else begin
            sync1_q <= {i_power_up_request_pin, i_status_one_raw, i_rail_good};
            sync2_q <= sync1_q;
        end
    end
    wire       wake_s    = sync2_q[13];
    wire [4:0] stat_one_s = sync2_q[12:8];
    wire [7:0] good_s    = sync2_q[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // register decode
    logic [7:0] allow_two_q;
    logic [7:0] slot_order_q;
    logic [7:0] status_two_q;
    wire wr_allow = i_reg_wr && (i_reg_addr == pis_pkg::OFS_IRQ_ALLOW_TWO);
    wire wr_slots = i_reg_wr && (i_reg_addr == pis_pkg::OFS_SLOT_ORDER);
    wire rd_stat2 = i_reg_rd && (i_reg_addr == pis_pkg::OFS_STATUS_TWO);
    wire [7:0] status_one = {3'h0, stat_one_s} << pis_pkg::STATUS_ONE_LSB;
    logic [7:0] rd_mux;
    always_comb begin
        case (i_reg_addr)
            pis_pkg::OFS_IRQ_ALLOW_TWO: rd_mux = allow_two_q;
            pis_pkg::OFS_STATUS_ONE:    rd_mux = status_one & pis_pkg::STATUS_ONE_MASK;
            pis_pkg::OFS_STATUS_TWO:    rd_mux = status_two_q & pis_pkg::ALLOW_TWO_MASK;
            pis_pkg::OFS_SLOT_ORDER:    rd_mux = slot_order_q;
            default:                    rd_mux = 8'h00;
        endcase
    end

    // writable registers and read data
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            allow_two_q  <= pis_pkg::ALLOW_TWO_RESET;
            slot_order_q <= pis_pkg::SLOT_ORDER_RESET;
            o_reg_rdata  <= 8'h00;
        end else begin
            if (wr_allow)
                allow_two_q <= i_reg_wdata & pis_pkg::ALLOW_TWO_MASK;
            if (wr_slots)
                slot_order_q <= i_reg_wdata;
            if (i_reg_rd)
                o_reg_rdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power sequencer
    pis_pkg::pis_seq_t seq_q;
    logic [1:0]  slot_q;
    logic [3:0]  wait_ms_q;
    logic [31:0] pre_q;
    logic [3:0]  rail_on_q;  // gate high, source pos, gate low, source neg
    logic        dcdc_on_q;
    logic        strobe_q;

    function automatic logic [3:0] slot_delay(input logic [1:0] idx);
        case (idx)
            2'h0:    slot_delay = i_first_slot_delay;
            2'h1:    slot_delay = i_slot_delay_two;
            2'h2:    slot_delay = i_slot_delay_three;
            default: slot_delay = i_slot_delay_four;
        endcase
    endfunction

    wire waiting = (seq_q == pis_pkg::PIS_UP) || (seq_q == pis_pkg::PIS_DOWN);
    wire fire    = waiting && (wait_ms_q == 4'h0);
    wire ms_tick = (pre_q == 32'(MS_CYC - 1));
    wire going_up = (seq_q == pis_pkg::PIS_UP);
    // power-down: slot 3 waits the first delay, then each slot the delay of the slot left
    wire [3:0] slot_hit;
    assign slot_hit[3] = slot_order_q[7:6] == slot_q;
    assign slot_hit[2] = slot_order_q[5:4] == slot_q;
    assign slot_hit[1] = slot_order_q[3:2] == slot_q;
    assign slot_hit[0] = slot_order_q[1:0] == slot_q;

    // state, slot pointer, delay counters
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            seq_q     <= pis_pkg::PIS_OFF;
            slot_q    <= 2'h0;
            wait_ms_q <= 4'h0;
            pre_q     <= 32'h0;
            strobe_q  <= 1'b0;
            dcdc_on_q <= 1'b0;
        end else begin
            strobe_q <= fire;
            pre_q    <= (!waiting || ms_tick || fire) ? 32'h0 : pre_q + 32'h1;
            if (waiting && !fire && ms_tick)
                wait_ms_q <= wait_ms_q - 4'h1;
            case (seq_q)
                pis_pkg::PIS_OFF, pis_pkg::PIS_UP: begin
                    if (!wake_s && seq_q == pis_pkg::PIS_UP) begin
                        seq_q     <= pis_pkg::PIS_DOWN;
                        slot_q    <= 2'h3;
                        wait_ms_q <= i_first_slot_delay;
                    end else if (wake_s && seq_q == pis_pkg::PIS_OFF) begin
                        seq_q     <= pis_pkg::PIS_UP;
                        slot_q    <= 2'h0;
                        wait_ms_q <= i_first_slot_delay;
                        dcdc_on_q <= 1'b1;
                    end else if (fire) begin
                        if (slot_q == 2'h3)
                            seq_q <= pis_pkg::PIS_ON;
                        slot_q    <= slot_q + 2'h1;
                        wait_ms_q <= slot_delay(slot_q + 2'h1);
                    end
                end
                pis_pkg::PIS_ON: begin
                    if (!wake_s) begin
                        seq_q     <= pis_pkg::PIS_DOWN;
                        slot_q    <= 2'h3;
                        wait_ms_q <= i_first_slot_delay;
                    end
                end
                pis_pkg::PIS_DOWN: begin
                    if (fire) begin
                        if (slot_q == 2'h0) begin
                            seq_q     <= pis_pkg::PIS_OFF;
                            dcdc_on_q <= 1'b0;
                        end
                        slot_q    <= slot_q - 2'h1;
                        wait_ms_q <= slot_delay(slot_q);
                    end
                end
                default: seq_q <= pis_pkg::PIS_OFF;
            endcase
        end
    end

    // rail enables follow the strobes
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            rail_on_q <= 4'h0;
        else if (fire && going_up)
            rail_on_q <= rail_on_q | slot_hit;
        else if (fire)
            rail_on_q <= rail_on_q & ~slot_hit;
    end

    // rail enables in status bit positions
    wire [7:0] rail_en;
    assign rail_en = {dcdc_on_q, rail_on_q[3], dcdc_on_q, rail_on_q[2], rail_on_q[1],
                      1'b0, rail_on_q[0], 1'b0};
    assign o_rail_on     = rail_en;
    assign o_slot_strobe = strobe_q;

    // slot index of the last strobe
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            o_slot_index <= 2'h0;
        else if (fire)
            o_slot_index <= slot_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // under-voltage timers, one per monitored rail
    logic [7:0] uv_hit;
    genvar g;
    generate
        for (g = 1; g < 8; g++) begin : g_uv
            if (g == pis_pkg::BIT_UNUSED) begin : g_none
                assign uv_hit[g] = 1'b0;
            end else begin : g_rail
                localparam int LIM = (g == pis_pkg::BIT_BOOST || g == pis_pkg::BIT_INVERTER)
                                     ? UV_LONG_CYC : UV_SHORT_CYC;
                localparam int CW = pis_pkg::UV_CNT_W;
                localparam logic [CW-1:0] LIM_V = LIM[CW-1:0];
                logic [pis_pkg::UV_CNT_W-1:0] cnt_q;
                wire run = rail_en[g] && !good_s[g];
                always_ff @(posedge i_mclk or posedge i_rst) begin
                    if (i_rst)
                        cnt_q <= '0;
                    else if (!rail_en[g] || good_s[g])
                        cnt_q <= '0;
                    else if (cnt_q != LIM_V)
                        cnt_q <= cnt_q + 1'b1;
                end
                assign uv_hit[g] = run && (cnt_q == LIM_V - 1'b1);
            end
        end
    endgenerate
    assign uv_hit[0] = i_conv_done;

    // sticky status two, cleared by a read, a new event wins
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            status_two_q <= 8'h00;
        else
            status_two_q <= ((rd_stat2 ? 8'h00 : status_two_q) | uv_hit)
                            & pis_pkg::ALLOW_TWO_MASK;
    end

    // interrupt output
    wire irq_d = |(status_two_q & allow_two_q) | |(status_one & i_status_one_allow);
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst)
            o_irq <= 1'b0;
        else
            o_irq <= irq_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    a_unused_bit_zero: assert property (allow_two_q[2] == 1'b0)
        else $error("unused enable bit is set");
    a_enable_write: assert property (wr_allow |=> allow_two_q == ($past(i_reg_wdata) & 8'hfb))
        else $error("enable write not stored");
    a_status_one_zero: assert property (i_reg_rd && i_reg_addr == 8'h07
        |=> (o_reg_rdata & 8'h83) == 8'h00)
        else $error("status one reserved bit nonzero");
    a_status_two_zero: assert property (i_reg_rd && i_reg_addr == 8'h08
        |=> o_reg_rdata[2] == 1'b0)
        else $error("status two bit 2 nonzero");
    a_uv_flag_set: assert property (|uv_hit
        |=> (status_two_q & $past(uv_hit)) == $past(uv_hit))
        else $error("undervolt flag missed");
    a_slot_write: assert property (wr_slots |=> slot_order_q == $past(i_reg_wdata))
        else $error("slot order write lost");
    sequence s_up_fire;
        fire && going_up && slot_order_q[7:6] == slot_q;
    endsequence
    a_slot_turn_on: assert property (s_up_fire |=> rail_on_q[3] ##1 rail_en[6])
        else $error("gate high rail not on at its strobe");
    a_down_order: assert property (fire && seq_q == pis_pkg::PIS_DOWN && slot_q != 2'h0
        |=> slot_q == $past(slot_q) - 2'h1)
        else $error("power-down order wrong");
    a_irq_follow: assert property (irq_d |=> o_irq)
        else $error("interrupt not raised");
    a_wake_delay: assert property (seq_q == pis_pkg::PIS_OFF && wake_s
        && i_first_slot_delay == 4'h0 |=> ##1 strobe_q)
        else $error("first strobe late");
    // read port, status flag, interrupt and power-down checks
    a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without a read");
    a_status_clear: assert property (rd_stat2 && !(|uv_hit)
        |=> status_two_q == 8'h00)
        else $error("status two not cleared by read");
    a_done_flag: assert property (i_conv_done |=> status_two_q[0])
        else $error("conversion done flag missed");
    a_irq_quiet: assert property (!irq_d |=> !o_irq)
        else $error("interrupt raised without cause");
    sequence s_down_fire;
        fire && !going_up;
    endsequence
    a_rail_off_down: assert property (s_down_fire
        |=> (rail_on_q & $past(slot_hit)) == 4'h0)
        else $error("rail left on at its down strobe");
    a_seq_end: assert property (s_down_fire ##0 slot_q == 2'h0
        |=> seq_q == pis_pkg::PIS_OFF && !dcdc_on_q && rail_on_q == 4'h0)
        else $error("rails on after power-down");
endmodule

// File: tb/pis_rail_model.sv
// rail partner model: reports regulation a few cycles after each enable
module pis_rail_model (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_rail_on,
    input  wire logic [7:0] i_break,
    output logic      [7:0] o_rail_good
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ramp1_q;
    logic [7:0] ramp2_q;
    // three-cycle ramp; a broken rail never comes into regulation
    always_ff @(posedge i_mclk) begin
        ramp1_q     <= i_rail_on;
        ramp2_q     <= ramp1_q;
        o_rail_good <= ramp2_q & ~i_break;
    end
endmodule

// File: tb/pis_regs_bench.sv
// self-checking bench for the interrupt and rail slot order registers
module pis_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, rst, wr, rd, wake, done, strobe, irq;
    logic [7:0] addr, wdata, allow1, brk, rdata, rail_on, good;
    logic [4:0] raw1;
    logic [3:0] first_slot_delay, dly_two, dly_three, dly_four;
    logic [1:0] idx;
    int         mismatches, n_tests, cnt;

    pis_regs #(.MS_CYC(4), .UV_SHORT_CYC(20), .UV_LONG_CYC(40)) i_pis_regs (
        .i_mclk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_power_up_request_pin(wake),
        .i_status_one_raw(raw1), .i_status_one_allow(allow1), .i_rail_good(good),
        .i_conv_done(done), .i_first_slot_delay(first_slot_delay), .i_slot_delay_two(dly_two),
        .i_slot_delay_three(dly_three), .i_slot_delay_four(dly_four), .o_rail_on(rail_on),
        .o_slot_strobe(strobe), .o_slot_index(idx), .o_irq(irq));
    pis_rail_model i_pis_rail_model (
        .i_mclk(clk), .i_rail_on(rail_on), .i_break(brk), .o_rail_good(good));

    ////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #400000;
        mismatches++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    task automatic pulse_done;
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
    endtask
    task automatic irq_is(input logic exp);
        repeat (4) @(posedge clk);
        #1;
        chk({7'h00, irq}, {7'h00, exp});
    endtask
    // per-slot rails on when their slot number is below n, converters while n is above 0
    function automatic logic [7:0] rails_for(input logic [7:0] ord, input int n);
        logic [7:0] m;
        m    = 8'h00;
        m[7] = n > 0;
        m[5] = n > 0;
        m[6] = int'(ord[7:6]) < n;
        m[4] = int'(ord[5:4]) < n;
        m[3] = int'(ord[3:2]) < n;
        m[1] = int'(ord[1:0]) < n;
        return m;
    endfunction
    task automatic seq_step(input int k, input int up, input logic [7:0] ord);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (strobe !== 1'b1 && cnt < 300);
        chk({7'h00, strobe}, 8'h01);
        chk({6'h00, idx}, 8'(k));
        @(posedge clk);
        #1;
        chk(rail_on & 8'hfa, rails_for(ord, k + up));
    endtask
    task automatic test_done;
        if (mismatches == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        {wr, rd, wake, done} = 4'h0;
        {addr, wdata, allow1, brk} = 32'h0;
        raw1 = 5'h00;
        first_slot_delay = 4'h1;
        {dly_two, dly_three, dly_four} = 12'h121;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_reg(pis_pkg::OFS_IRQ_ALLOW_TWO, 8'hfb);
        rd_reg(pis_pkg::OFS_SLOT_ORDER, 8'he4);
        rd_reg(pis_pkg::OFS_STATUS_TWO, 8'h00);
        rd_reg(8'h20, 8'h00);
        wr_reg(pis_pkg::OFS_IRQ_ALLOW_TWO, 8'hff);
        rd_reg(pis_pkg::OFS_IRQ_ALLOW_TWO, 8'hfb);
        wr_reg(pis_pkg::OFS_STATUS_ONE, 8'hff);
        rd_reg(pis_pkg::OFS_STATUS_ONE, 8'h00);
        @(posedge clk);
        raw1 <= 5'h1f;
        irq_is(1'b0);
        rd_reg(pis_pkg::OFS_STATUS_ONE, 8'h7c);
        @(posedge clk);
        allow1 <= 8'h40;
        irq_is(1'b1);
        @(posedge clk);
        allow1 <= 8'h00;
        irq_is(1'b0);
        pulse_done();
        irq_is(1'b1);
        rd_reg(pis_pkg::OFS_STATUS_TWO, 8'h01);
        irq_is(1'b0);
        rd_reg(pis_pkg::OFS_STATUS_TWO, 8'h00);
        wr_reg(pis_pkg::OFS_IRQ_ALLOW_TWO, 8'h00);
        pulse_done();
        irq_is(1'b0);
        rd_reg(pis_pkg::OFS_STATUS_TWO, 8'h01);
        wr_reg(pis_pkg::OFS_IRQ_ALLOW_TWO, 8'hfb);
        // power-up with gate low rail stuck below regulation
        wr_reg(pis_pkg::OFS_SLOT_ORDER, 8'h1b);
        rd_reg(pis_pkg::OFS_SLOT_ORDER, 8'h1b);
        @(posedge clk);
        brk  <= 8'h08;
        first_slot_delay <= 4'h3;
        wake <= 1'b1;
        seq_step(0, 1, 8'h1b);
        chk({7'h00, cnt >= 12 && cnt <= 20}, 8'h01);
        for (int k = 1; k < 4; k++) seq_step(k, 1, 8'h1b);
        repeat (40) @(posedge clk);
        irq_is(1'b1);
        rd_reg(pis_pkg::OFS_STATUS_TWO, 8'h08);
        @(posedge clk);
        wake <= 1'b0;
        seq_step(3, 0, 8'h1b);
        chk({7'h00, cnt >= 12 && cnt <= 20}, 8'h01);
        for (int k = 2; k >= 0; k--) seq_step(k, 0, 8'h1b);
        // second power-up with a zero first delay
        @(posedge clk);
        first_slot_delay <= 4'h0;
        wake <= 1'b1;
        seq_step(0, 1, 8'h1b);
        chk(8'(cnt), 8'h04);
        test_done();
    end
endmodule
